//--- src/hcu_hibernation_ctrl.sv
// Purpose: hibernation control unit top: enable, clocking, memory,
//   pin retention and interrupt status
// Assumes: all control strobes and gpio inputs come from clk_in logic
// Notes: only the clock pins are synchronised
// Overview of operation
// RULE_01: oscillator-off setting powers down the internal slow oscillator.
// RULE_02: two crystal drive strengths, strong for large, weak for small caps.
// RULE_03: slow clock is raw oscillator or fast crystal divided by 128.
// RULE_04: sixteen 32-bit battery-backed words survive processor power loss.
// RULE_05: memory reads return the words last written.
// RULE_06: disabled unit offers no clocking, memory, wake or interrupts.
// RULE_07: software enables the unit before using any function.
// RULE_08: with retention on, pins latch during hibernation and hold after wake.
// RULE_09: on hibernation entry retained values drive pins, not gpio block.
// RULE_10: releasing retention hands pins back; software reconfigures gpio first.
// RULE_11: retention setting reads one when enabled, zero when disabled.
// RULE_12: pending interrupt stays set until software clears it.
// RULE_13: software clears interrupt sources early in the handler.
// RULE_14: per-source mask bit; cleared mask keeps source off the output.
// RULE_15: five sources share bit positions for enable, status and clear.
// RULE_16: status readable raw and masked by the enable bits.
// RULE_17: writing one clears a pending bit, zero leaves it.
// RULE_18: clock switch is glitch free; drive stays fixed while crystal runs.
`timescale 1ns/10ps
`default_nettype none
module hcu_hibernation_ctrl
  import hcu_pkg::*;
#(
  parameter int PINS = HCU_PINS
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // unit enable
  input wire logic unit_enable_in,
  input wire logic unit_disable_in,
  output logic unit_active_out,
  // oscillator and clock source
  input wire logic osc_cfg_wr_in,
  input wire hcu_pkg::hcu_osc_cfg_t osc_cfg_in,
  input wire logic clk_src_wr_in,
  input wire hcu_pkg::hcu_clk_src_t clk_src_in,
  input wire logic osc_raw_in,
  input wire logic fast_xtal_in,
  output logic osc_power_off_out,
  output logic osc_strong_drive_out,
  output logic osc_weak_drive_out,
  output logic clk_src_fast_divided_out,
  output logic slow_clk_out,
  output logic slow_tick_out,
  // battery-backed memory
  input wire logic backup_mem_write_in,
  input wire logic backup_mem_read_in,
  input wire logic [HCU_ADDR_W-1:0] backup_mem_addr_in,
  input wire logic [HCU_DATA_W-1:0] backup_mem_wdata_in,
  output logic [HCU_DATA_W-1:0] backup_mem_rdata_out,
  output logic backup_mem_rvalid_out,
  // pin retention
  input wire logic pin_hold_set_in,
  input wire logic pin_hold_release_in,
  input wire logic hib_entry_in,
  input wire logic [PINS-1:0] gpio_out_in,
  input wire logic [PINS-1:0] gpio_oe_n_in,
  output logic [PINS-1:0] pin_out_out,
  output logic [PINS-1:0] pin_oe_n_out,
  output logic pin_hold_out,
  // interrupts
  input wire logic [HCU_IRQ_N-1:0] irq_event_in,
  input wire logic [HCU_IRQ_N-1:0] irq_en_set_in,
  input wire logic [HCU_IRQ_N-1:0] irq_en_clr_in,
  input wire logic [HCU_IRQ_N-1:0] irq_pending_clear_in,
  output logic [HCU_IRQ_N-1:0] irq_raw_out,
  output logic [HCU_IRQ_N-1:0] irq_masked_out,
  output logic irq_out
);

  // enable and oscillator state
  logic en_q, en_d;
  hcu_osc_cfg_t osc_cfg_q, osc_cfg_d;
  hcu_clk_src_t clk_src_q, clk_src_d;
  logic osc_off_q, osc_off_d, strong_q, strong_d, weak_q, weak_d;
  logic fast_sel_q, fast_sel_d;
  logic xtal_running;

  always_comb begin
    en_d = en_q;
    if (unit_disable_in) begin
      en_d = 1'b0;
    end else if (unit_enable_in) begin
      en_d = 1'b1; // [RULE_07]
    end
    xtal_running = en_q && (osc_cfg_q != HCU_OSC_POWER_OFF);
    osc_cfg_d = osc_cfg_q;
    if (osc_cfg_wr_in) begin
      // a drive change under a running crystal is dropped [RULE_18]
      if (osc_cfg_in == HCU_OSC_POWER_OFF) begin
        osc_cfg_d = HCU_OSC_POWER_OFF; // [RULE_01]
      end else if (osc_cfg_in == HCU_OSC_STRONG_DRIVE && !xtal_running) begin
        osc_cfg_d = HCU_OSC_STRONG_DRIVE; // [RULE_02]
      end else if (osc_cfg_in == HCU_OSC_WEAK_DRIVE && !xtal_running) begin
        osc_cfg_d = HCU_OSC_WEAK_DRIVE; // [RULE_02]
      end
    end
    clk_src_d = clk_src_q;
    if (clk_src_wr_in && en_q) begin
      clk_src_d = clk_src_in; // [RULE_03]
    end
    // a disabled unit keeps its oscillator down [RULE_06]
    osc_off_d = !en_d || (osc_cfg_d == HCU_OSC_POWER_OFF); // [RULE_01]
    strong_d = en_d && (osc_cfg_d == HCU_OSC_STRONG_DRIVE); // [RULE_02]
    weak_d = en_d && (osc_cfg_d == HCU_OSC_WEAK_DRIVE); // [RULE_02]
    fast_sel_d = (clk_src_d == HCU_CLK_SRC_FAST_DIVIDED);
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      en_q <= HCU_ENABLE_RST;
      osc_cfg_q <= HCU_OSC_POWER_OFF;
      clk_src_q <= HCU_CLK_SRC_RAW;
      osc_off_q <= 1'b1;
      strong_q <= 1'b0;
      weak_q <= 1'b0;
      fast_sel_q <= 1'b0;
    end else begin
      en_q <= en_d;
      osc_cfg_q <= osc_cfg_d;
      clk_src_q <= clk_src_d;
      osc_off_q <= osc_off_d;
      strong_q <= strong_d;
      weak_q <= weak_d;
      fast_sel_q <= fast_sel_d;
    end
  end

  // the fast crystal path runs even with the internal oscillator down
  hcu_clk_src u_clk_src (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .run_in(en_d), // [RULE_06]
    .src_sel_in(clk_src_q),
    .osc_raw_in(osc_raw_in),
    .fast_xtal_in(fast_xtal_in),
    .slow_clk_out(slow_clk_out),
    .slow_tick_out(slow_tick_out)
  );

  hcu_backup_mem #(
    .WORDS(HCU_MEM_WORDS),
    .DATA_W(HCU_DATA_W),
    .ADDR_W(HCU_ADDR_W)
  ) u_backup_mem (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .enable_in(en_q), // [RULE_06]
    .wr_in(backup_mem_write_in),
    .rd_in(backup_mem_read_in),
    .addr_in(backup_mem_addr_in),
    .wdata_in(backup_mem_wdata_in),
    .rdata_out(backup_mem_rdata_out),
    .rvalid_out(backup_mem_rvalid_out)
  );

  // pin retention state
  logic hold_q, hold_d, frozen_q, frozen_d, hib_prev_q;
  logic [PINS-1:0] latch_out_q, latch_out_d, latch_oe_n_q, latch_oe_n_d;
  logic [PINS-1:0] pin_out_q, pin_out_d, pin_oe_n_q, pin_oe_n_d;
  logic hib_rise;

  always_comb begin
    hib_rise = hib_entry_in && !hib_prev_q;
    hold_d = hold_q;
    if (pin_hold_release_in) begin
      hold_d = 1'b0; // [RULE_10]
    end else if (pin_hold_set_in && en_q) begin
      hold_d = 1'b1; // [RULE_08]
    end
    frozen_d = frozen_q;
    if (!hold_d) begin
      frozen_d = 1'b0; // [RULE_10]
    end else if (hib_rise) begin
      frozen_d = 1'b1; // [RULE_09]
    end
    // the gpio block is already in reset on the entry cycle, so keep
    // the levels sampled just before it
    latch_out_d = latch_out_q;
    latch_oe_n_d = latch_oe_n_q;
    if (!frozen_q && !hib_entry_in) begin
      latch_out_d = gpio_out_in;
      latch_oe_n_d = gpio_oe_n_in;
    end
    if (frozen_d) begin
      pin_out_d = latch_out_d; // [RULE_08]
      pin_oe_n_d = latch_oe_n_d; // [RULE_09]
    end else begin
      pin_out_d = gpio_out_in; // [RULE_10]
      pin_oe_n_d = gpio_oe_n_in;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hold_q <= HCU_HOLD_RST;
      frozen_q <= 1'b0;
      hib_prev_q <= 1'b0;
      latch_out_q <= '0;
      latch_oe_n_q <= '1;
      pin_out_q <= '0;
      pin_oe_n_q <= '1;
    end else begin
      hold_q <= hold_d;
      frozen_q <= frozen_d;
      hib_prev_q <= hib_entry_in;
      latch_out_q <= latch_out_d;
      latch_oe_n_q <= latch_oe_n_d;
      pin_out_q <= pin_out_d;
      pin_oe_n_q <= pin_oe_n_d;
    end
  end

  // interrupt state
  logic [HCU_IRQ_N-1:0] raw_q, raw_d, mask_q, mask_d, masked_q, masked_d;
  logic irq_q, irq_d;

  always_comb begin
    // a source arriving with its clear is kept [RULE_12]
    raw_d = raw_q & ~irq_pending_clear_in; // [RULE_17]
    if (en_q) begin
      raw_d = raw_d | irq_event_in; // [RULE_15]
    end
    mask_d = (mask_q & ~irq_en_clr_in) | irq_en_set_in; // [RULE_14]
    masked_d = raw_d & mask_d; // [RULE_16]
    irq_d = en_d && (|masked_d); // [RULE_14]
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      raw_q <= HCU_IRQ_RAW_RST;
      mask_q <= HCU_IRQ_EN_RST;
      masked_q <= '0;
      irq_q <= 1'b0;
    end else begin
      raw_q <= raw_d;
      mask_q <= mask_d;
      masked_q <= masked_d;
      irq_q <= irq_d;
    end
  end

  assign unit_active_out = en_q;
  assign osc_power_off_out = osc_off_q;
  assign osc_strong_drive_out = strong_q;
  assign osc_weak_drive_out = weak_q;
  assign clk_src_fast_divided_out = fast_sel_q;
  assign pin_out_out = pin_out_q;
  assign pin_oe_n_out = pin_oe_n_q;
  assign pin_hold_out = hold_q; // [RULE_11]
  assign irq_raw_out = raw_q;
  assign irq_masked_out = masked_q;
  assign irq_out = irq_q;

  logic [HCU_IRQ_N-1:0] clr_only, set_and_clr;
  assign clr_only = irq_pending_clear_in & ~irq_event_in;
  assign set_and_clr = irq_pending_clear_in & irq_event_in;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_hold_entry;
    hold_q && hib_rise && !pin_hold_release_in;
  endsequence

  sequence s_no_release;
    !pin_hold_release_in [*2];
  endsequence

  a_osc_off: assert property ( // [RULE_01]
    osc_cfg_wr_in && osc_cfg_in == HCU_OSC_POWER_OFF |=> osc_power_off_out)
    else $error("oscillator not powered down");

  a_drive_excl: assert property ( // [RULE_02]
    !(osc_strong_drive_out && osc_weak_drive_out) &&
    !(osc_power_off_out && (osc_strong_drive_out || osc_weak_drive_out)))
    else $error("oscillator drive settings overlap");

  a_drive_stable: assert property ( // [RULE_18]
    osc_strong_drive_out && unit_active_out && !unit_disable_in &&
    osc_cfg_wr_in && osc_cfg_in == HCU_OSC_WEAK_DRIVE
    |=> osc_strong_drive_out)
    else $error("drive changed while crystal running");

  a_disabled_quiet: assert property ( // [RULE_06]
    !unit_active_out |-> !irq_out && osc_power_off_out && !slow_tick_out)
    else $error("disabled unit still active");

  a_hold_status: assert property ( // [RULE_11]
    unit_active_out && pin_hold_set_in && !pin_hold_release_in
    ##1 !pin_hold_release_in |=> pin_hold_out)
    else $error("retention setting not reported");

  a_hold_freeze: assert property ( // [RULE_08]
    s_hold_entry ##1 s_no_release |=>
      pin_out_out == $past(pin_out_out, 2) &&
      pin_oe_n_out == $past(pin_oe_n_out, 2))
    else $error("retained pins moved during hold");

  a_release_back: assert property ( // [RULE_10]
    pin_hold_release_in |=> !pin_hold_out &&
      pin_out_out == $past(gpio_out_in) &&
      pin_oe_n_out == $past(gpio_oe_n_in))
    else $error("pins not handed back on release");

  a_irq_sticky: assert property ( // [RULE_12]
    1'b1 |=> (($past(irq_raw_out) & ~$past(irq_pending_clear_in))
      & ~irq_raw_out) == '0)
    else $error("pending bit dropped without clear");

  a_irq_clear: assert property ( // [RULE_17]
    (|clr_only) |=> (irq_raw_out & $past(clr_only)) == '0)
    else $error("clear write did not clear status");

  a_set_wins: assert property ( // [RULE_15]
    unit_active_out && (|set_and_clr) |=>
      (irq_raw_out & $past(set_and_clr)) == $past(set_and_clr))
    else $error("event lost under simultaneous clear");

  a_masked_and: assert property ( // [RULE_16]
    irq_masked_out == (irq_raw_out & mask_q) &&
    (irq_out -> (|irq_masked_out)))
    else $error("masked status or output mismatch");

endmodule : hcu_hibernation_ctrl
`default_nettype wire

//--- src/hcu_pkg.sv
// Purpose: shared constants and types of the hibernation control unit
// Assumes: one clock domain, clk_in at 250 MHz
// Notes: interrupt bit positions serve enable, status and clear alike
package hcu_pkg;

  // interrupt sources, one bit each
  localparam int HCU_IRQ_N = 5;
  localparam int HCU_IRQ_WR_DONE = 0;
  localparam int HCU_IRQ_PIN_WAKE = 1;
  localparam int HCU_IRQ_BATTERY_LOW = 2;
  localparam int HCU_IRQ_MATCH0 = 3;
  localparam int HCU_IRQ_MATCH1 = 4;

  // battery-backed memory
  localparam int HCU_MEM_WORDS = 16;
  localparam int HCU_DATA_W = 32;
  localparam int HCU_ADDR_W = 4;

  // fast crystal divider, ratio and half period in fast edges
  localparam int HCU_DIV_RATIO = 128;
  localparam int HCU_DIV_HALF = HCU_DIV_RATIO / 2;
  localparam int HCU_DIV_W = $clog2(HCU_DIV_HALF);

  // retained pins
  localparam int HCU_PINS = 8;

  // reset values
  localparam logic HCU_ENABLE_RST = 1'b0;
  localparam logic HCU_HOLD_RST = 1'b0;
  localparam logic [HCU_IRQ_N-1:0] HCU_IRQ_EN_RST = 5'h00;
  localparam logic [HCU_IRQ_N-1:0] HCU_IRQ_RAW_RST = 5'h00;

  typedef enum logic [1:0] {
    HCU_OSC_POWER_OFF,
    HCU_OSC_STRONG_DRIVE,
    HCU_OSC_WEAK_DRIVE
  } hcu_osc_cfg_t;

  typedef enum logic {
    HCU_CLK_SRC_RAW,
    HCU_CLK_SRC_FAST_DIVIDED
  } hcu_clk_src_t;

endpackage : hcu_pkg

//--- src/hcu_clk_src.sv
// Purpose: slow clock source select with fast crystal divider
// Assumes: both clock pins are far slower than clk_in
// Notes: the slow clock is a sampled level, not a real clock net
`timescale 1ns/10ps
`default_nettype none
module hcu_clk_src
  import hcu_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // control
  input wire logic run_in,
  input wire hcu_pkg::hcu_clk_src_t src_sel_in,
  // pins
  input wire logic osc_raw_in,
  input wire logic fast_xtal_in,
  // slow clock
  output logic slow_clk_out,
  output logic slow_tick_out
);

  logic raw_s1_q, raw_s2_q, fast_s1_q, fast_s2_q, fast_prev_q;
  logic [HCU_DIV_W-1:0] div_cnt_q, div_cnt_d;
  logic div_clk_q, div_clk_d;
  hcu_clk_src_t active_q, active_d;
  logic slow_q, slow_d, tick_q, tick_d;
  logic fast_rise, cand;

  always_comb begin
    fast_rise = fast_s2_q & ~fast_prev_q;
    div_cnt_d = div_cnt_q;
    div_clk_d = div_clk_q;
    if (fast_rise) begin
      div_cnt_d = div_cnt_q + {{(HCU_DIV_W-1){1'b0}}, 1'b1}; // [RULE_03]
      if (div_cnt_q == HCU_DIV_W'(HCU_DIV_HALF - 1)) begin
        div_clk_d = ~div_clk_q; // [RULE_03]
      end
    end
    // switch only when the new source matches the output level [RULE_18]
    cand = (src_sel_in == HCU_CLK_SRC_FAST_DIVIDED) ? div_clk_q : raw_s2_q;
    active_d = active_q;
    // a stopped unit forces the output low, so it must not switch then
    if (run_in && src_sel_in != active_q && cand == slow_q) begin
      active_d = src_sel_in; // [RULE_18]
    end
    if (!run_in) begin
      slow_d = 1'b0;
    end else if (active_d == HCU_CLK_SRC_FAST_DIVIDED) begin
      slow_d = div_clk_q; // [RULE_03]
    end else begin
      slow_d = raw_s2_q; // [RULE_03]
    end
    tick_d = slow_d & ~slow_q;
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      raw_s1_q <= 1'b0;
      raw_s2_q <= 1'b0;
      fast_s1_q <= 1'b0;
      fast_s2_q <= 1'b0;
      fast_prev_q <= 1'b0;
      div_cnt_q <= '0;
      div_clk_q <= 1'b0;
      active_q <= HCU_CLK_SRC_RAW;
      slow_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      raw_s1_q <= osc_raw_in;
      raw_s2_q <= raw_s1_q;
      fast_s1_q <= fast_xtal_in;
      fast_s2_q <= fast_s1_q;
      fast_prev_q <= fast_s2_q;
      div_cnt_q <= div_cnt_d;
      div_clk_q <= div_clk_d;
      active_q <= active_d;
      slow_q <= slow_d;
      tick_q <= tick_d;
    end
  end

  assign slow_clk_out = slow_q;
  assign slow_tick_out = tick_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  a_div_toggle: assert property ( // [RULE_03]
    (div_clk_q != $past(div_clk_q)) |->
      ($past(div_cnt_q) == HCU_DIV_W'(HCU_DIV_HALF - 1)) && $past(fast_rise))
    else $error("divided clock toggled off its terminal count");

  a_switch_clean: assert property ( // [RULE_18]
    (active_q != $past(active_q)) |-> (slow_q == $past(slow_q)))
    else $error("slow clock glitched on source switch");

endmodule : hcu_clk_src
`default_nettype wire

//--- src/hcu_backup_mem.sv
// Purpose: battery-backed word memory
// Assumes: one access per cycle, write takes priority over read
// Notes: out-of-range addresses drop writes and read as zero
`timescale 1ns/10ps
`default_nettype none
module hcu_backup_mem
  import hcu_pkg::*;
#(
  parameter int WORDS = HCU_MEM_WORDS,
  parameter int DATA_W = HCU_DATA_W,
  parameter int ADDR_W = HCU_ADDR_W
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // access
  input wire logic enable_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  // answer
  output logic [DATA_W-1:0] rdata_out,
  output logic rvalid_out
);

  logic [DATA_W-1:0] mem_q [WORDS];
  logic [DATA_W-1:0] mem_d [WORDS];
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic in_range;

  always_comb begin
    in_range = (int'(addr_in) < WORDS);
    mem_d = mem_q;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    if (enable_in && wr_in && in_range) begin
      mem_d[addr_in] = wdata_in; // [RULE_04]
    end else if (enable_in && rd_in) begin
      rvalid_d = 1'b1;
      rdata_d = in_range ? mem_q[addr_in] : '0; // [RULE_05]
    end
  end

  // contents only clear at battery power-on, never on processor wake
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_q[i] <= '0;
      end
      rdata_q <= '0;
      rvalid_q <= 1'b0;
    end else begin
      mem_q <= mem_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign rdata_out = rdata_q;
  assign rvalid_out = rvalid_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_write;
    enable_in && wr_in && in_range;
  endsequence

  a_mem_readback: assert property ( // [RULE_05]
    s_write ##1 (enable_in && rd_in && !wr_in &&
      addr_in == $past(addr_in)) |=> rvalid_out &&
      rdata_out == $past(wdata_in, 2))
    else $error("read did not return last written word");

  a_mem_off: assert property ( // [RULE_06]
    !enable_in |=> !rvalid_out)
    else $error("memory answered while unit disabled");

endmodule : hcu_backup_mem
`default_nettype wire

//--- test/hcu_pin_model.sv
// Purpose: crystal pins and gpio block on the far side of the unit
// Assumes: pin half periods unrelated in phase to clk_in
// Notes: time-based generators, not synthesizable
`timescale 1ns/10ps
`default_nettype none
module hcu_pin_model #(
  parameter real RAW_HALF = 41.3,
  parameter real FAST_HALF = 11.7,
  parameter int PINS = 8
) (
  // control
  input wire logic run_in,
  input wire logic hib_in,
  input wire logic [PINS-1:0] cfg_val_in,
  input wire logic [PINS-1:0] cfg_oe_n_in,
  // pins
  output logic osc_raw_out,
  output logic fast_xtal_out,
  output logic [PINS-1:0] gpio_out_out,
  output logic [PINS-1:0] gpio_oe_n_out
);
  initial begin
    osc_raw_out = 1'b0;
    fast_xtal_out = 1'b0;
  end
  // a powered-down oscillator gives no clock at all
  always #(RAW_HALF) osc_raw_out = run_in ? ~osc_raw_out : 1'b0;
  always #(FAST_HALF) fast_xtal_out = ~fast_xtal_out;
  // gpio block in reset: junk levels, so a leak cannot pass
  assign gpio_out_out = hib_in ? ~cfg_val_in : cfg_val_in;
  assign gpio_oe_n_out = hib_in ? {PINS{1'b1}} : cfg_oe_n_in;
endmodule : hcu_pin_model
`default_nettype wire

//--- test/hcu_hibernation_ctrl_tb.sv
// Purpose: self-checking bench of the hibernation control unit
// Assumes: inputs change 1 ns after the rising clock edge
// Notes: tick gaps are checked with a tolerance for pin synchronisers
`timescale 1ns/10ps
`default_nettype none
module hcu_hibernation_ctrl_tb;
  import hcu_pkg::*;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic en = 0, dis = 0, ocw = 0, csw = 0, mw = 0, mr = 0;
  logic hs = 0, hr = 0, hib = 0;
  hcu_osc_cfg_t oc = HCU_OSC_POWER_OFF;
  hcu_clk_src_t cs = HCU_CLK_SRC_RAW;
  logic [3:0] ma = 4'h0;
  logic [31:0] md = 32'h0;
  logic [7:0] gv = 8'h00, goe = 8'hFF;
  logic [4:0] ev = 5'h00, es = 5'h00, ec = 5'h00, pc = 5'h00;
  logic [4:0] b, r1, r2;
  logic [15:0] p;
  wire logic act, opo, osd, owd, cfd, sclk, stick, rv, ph, irq, oraw, fx;
  wire logic [31:0] rd;
  wire logic [7:0] po, poe, go, goen;
  wire logic [4:0] raw, msk;
  int errors = 0, n_compared = 0, seed;
  logic [31:0] mem [16];
  real g;

  always #2 clk_in = ~clk_in;

  hcu_pin_model #(.PINS(8)) u_pins (.run_in(~opo), .hib_in(hib),
    .cfg_val_in(gv), .cfg_oe_n_in(goe), .osc_raw_out(oraw),
    .fast_xtal_out(fx), .gpio_out_out(go), .gpio_oe_n_out(goen));

  hcu_hibernation_ctrl #(.PINS(8)) u_dut (
    .clk_in(clk_in), .reset_n_in(reset_n_in),
    .unit_enable_in(en), .unit_disable_in(dis), .unit_active_out(act),
    .osc_cfg_wr_in(ocw), .osc_cfg_in(oc), .clk_src_wr_in(csw),
    .clk_src_in(cs), .osc_raw_in(oraw), .fast_xtal_in(fx),
    .osc_power_off_out(opo), .osc_strong_drive_out(osd),
    .osc_weak_drive_out(owd), .clk_src_fast_divided_out(cfd),
    .slow_clk_out(sclk), .slow_tick_out(stick),
    .backup_mem_write_in(mw), .backup_mem_read_in(mr),
    .backup_mem_addr_in(ma), .backup_mem_wdata_in(md),
    .backup_mem_rdata_out(rd), .backup_mem_rvalid_out(rv),
    .pin_hold_set_in(hs), .pin_hold_release_in(hr), .hib_entry_in(hib),
    .gpio_out_in(go), .gpio_oe_n_in(goen), .pin_out_out(po),
    .pin_oe_n_out(poe), .pin_hold_out(ph), .irq_event_in(ev),
    .irq_en_set_in(es), .irq_en_clr_in(ec), .irq_pending_clear_in(pc),
    .irq_raw_out(raw), .irq_masked_out(msk), .irq_out(irq));

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : step

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask : chk

  task automatic chk_near(input string nm, input real e, input real s);
    n_compared++;
    if (s < e - 9.0 || s > e + 9.0) begin
      errors++;
      $display("BAD %s exp %0.1f got %0.1f", nm, e, s);
    end
  endtask : chk_near

  function automatic logic [10:0] irq_exp(input logic [4:0] pend,
                                          input logic [4:0] en_mask);
    return {pend, pend & en_mask, |(pend & en_mask)};
  endfunction : irq_exp

  task automatic osc_wr(input hcu_osc_cfg_t c, input logic [2:0] e);
    oc = c;
    ocw = 1'b1;
    step(1);
    ocw = 1'b0;
    chk("osc off/strong/weak", {29'h0, e}, {29'h0, opo, osd, owd});
    step(1);
  endtask : osc_wr

  // time between two slow ticks, bounded so a dead clock cannot hang
  task automatic tick_gap(output real gap);
    real t0;
    int k;
    k = 0;
    while (stick !== 1'b1 && k < 2000) begin
      step(1);
      k++;
    end
    t0 = $realtime;
    step(1);
    k = 0;
    while (stick !== 1'b1 && k < 2000) begin
      step(1);
      k++;
    end
    gap = $realtime - t0;
  endtask : tick_gap

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    #100000;
    errors++;
    end_sim();
  end

  initial begin
    seed = $urandom(32'hF930D64D);
    step(16);
    reset_n_in = 1'b1;
    step(1);
    chk("reset", 32'h0000FF80, {act, opo, poe, ph, raw, sclk});
    // disabled unit refuses reads, hold set, events and clock source writes
    mr = 1'b1;
    hs = 1'b1;
    ev = 5'h1F;
    csw = 1'b1;
    cs = HCU_CLK_SRC_FAST_DIVIDED;
    step(1);
    chk("disabled", 32'h0, {rv, ph, cfd, raw});
    mr = 1'b0;
    hs = 1'b0;
    ev = 5'h00;
    csw = 1'b0;
    en = 1'b1;
    step(1);
    en = 1'b0;
    chk("active", 32'h1, act);
    $display("done: reset and enable");
    osc_wr(HCU_OSC_WEAK_DRIVE, 3'b001);
    osc_wr(HCU_OSC_STRONG_DRIVE, 3'b001);
    osc_wr(HCU_OSC_POWER_OFF, 3'b100);
    osc_wr(HCU_OSC_STRONG_DRIVE, 3'b010);
    osc_wr(hcu_osc_cfg_t'(2'h3), 3'b010);
    osc_wr(HCU_OSC_WEAK_DRIVE, 3'b010);
    $display("done: oscillator");
    cs = HCU_CLK_SRC_RAW;
    csw = 1'b1;
    step(1);
    csw = 1'b0;
    chk("src", 32'h0, cfd);
    tick_gap(g);
    tick_gap(g);
    chk_near("raw gap", 82.6, g);
    cs = HCU_CLK_SRC_FAST_DIVIDED;
    csw = 1'b1;
    step(1);
    csw = 1'b0;
    chk("src", 32'h1, cfd);
    repeat (3) tick_gap(g);
    chk_near("divided gap", 128 * 23.4, g);
    cs = HCU_CLK_SRC_RAW;
    csw = 1'b1;
    step(1);
    csw = 1'b0;
    // switching may stretch a period but never shorten it to a sliver
    repeat (4) begin
      tick_gap(g);
      chk("no glitch", 32'h1, g > 36.0);
    end
    chk_near("raw gap", 82.6, g);
    $display("done: clock source");
    mw = 1'b1;
    for (int i = 0; i < 16; i++) begin
      ma = i[3:0];
      md = $urandom;
      mem[i] = md;
      step(1);
    end
    mw = 1'b0;
    mr = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      ma = i[3:0];
      step(1);
      chk("rdata", mem[i], rd);
      chk("rvalid", 32'h1, rv);
    end
    mr = 1'b0;
    mw = 1'b1;
    ma = 4'h5;
    md = $urandom;
    mem[5] = md;
    step(1);
    mw = 1'b0;
    mr = 1'b1;
    step(1);
    mr = 1'b0;
    chk("rdata", mem[5], rd);
    $display("done: backup memory");
    for (int i = 0; i < 5; i++) begin
      b = 5'h01 << i;
      es = b;
      step(1);
      es = 5'h00;
      ev = b;
      step(1);
      ev = 5'h00;
      chk("raw/masked/irq", irq_exp(b, b), {raw, msk, irq});
      pc = ~b;
      step(1);
      pc = 5'h00;
      step(4);
      chk("pending", b, raw);
      ec = b;
      step(1);
      ec = 5'h00;
      chk("masked off", irq_exp(b, 5'h00), {raw, msk, irq});
      pc = b;
      step(1);
      pc = 5'h00;
      chk("cleared", 32'h0, raw);
    end
    repeat (4) begin
      r1 = 5'($urandom);
      r2 = 5'($urandom);
      es = r1;
      ec = ~r1;
      step(1);
      es = 5'h00;
      ec = 5'h00;
      ev = r2;
      step(1);
      ev = 5'h00;
      chk("status", irq_exp(r2, r1), {raw, msk, irq});
      // an event landing on its own clear must survive
      pc = 5'h1F;
      ev = r1;
      step(1);
      ev = 5'h00;
      chk("set wins", r1, raw);
      step(1);
      pc = 5'h00;
      chk("cleared", 32'h0, raw);
    end
    $display("done: interrupts");
    gv = 8'($urandom);
    goe = 8'($urandom);
    step(3);
    chk("pins follow", {gv, goe}, {po, poe});
    hs = 1'b1;
    step(1);
    hs = 1'b0;
    chk("hold", 32'h1, ph);
    p = {gv, goe};
    hib = 1'b1;
    gv = 8'($urandom);
    step(4);
    chk("frozen", p, {po, poe});
    // software reconfigures gpio before releasing the pins
    hib = 1'b0;
    gv = 8'($urandom);
    goe = 8'($urandom);
    step(3);
    chk("held on wake", p, {po, poe});
    hr = 1'b1;
    step(1);
    hr = 1'b0;
    chk("released", {1'b0, gv, goe}, {ph, po, poe});
    $display("done: retention");
    dis = 1'b1;
    en = 1'b1;
    step(1);
    dis = 1'b0;
    en = 1'b0;
    chk("disable", 32'h1, {act, opo});
    ev = 5'h1F;
    mr = 1'b1;
    step(1);
    ev = 5'h00;
    mr = 1'b0;
    step(2);
    chk("off", 32'h0, {sclk, raw, irq, rv});
    en = 1'b1;
    step(1);
    en = 1'b0;
    mr = 1'b1;
    ma = 4'h7;
    step(1);
    mr = 1'b0;
    chk("kept", mem[7], rd);
    $display("done: disable");
    end_sim();
  end
endmodule : hcu_hibernation_ctrl_tb
`default_nettype wire
